// file: common/vps_pkg.sv
// Purpose: Shared constants and types for the valve leak test scheduler
// Assumes: One 25 MHz clock; times counted in whole seconds
// Notes:   Settings arrive from the commissioning logic on the same clock

package vpr_pkg;

  // ----------------------------------------------------------------------
  // Clock and phase times
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 32'h017D_7840; // 25 MHz
  localparam int unsigned SEC_PER_S  = 32'h0000_0001; // Prescaler unit
  localparam int unsigned VALVE_S    = 32'h0000_0004; // Vent or fill time
  localparam int unsigned SETTLE_S   = 32'h0000_0003; // Switch ignored

  // ----------------------------------------------------------------------
  // Test time setting: step code to seconds
  // ----------------------------------------------------------------------
  localparam int          CODE_W     = 8;
  localparam int          SECS_W     = 12;
  localparam logic [7:0]  CODE_1S    = 8'h3C;  // Last 1 s step (60 s)
  localparam logic [7:0]  CODE_10S   = 8'h72;  // Last 10 s step (600 s)
  localparam logic [7:0]  CODE_MAX   = 8'hA4;  // Last 1 min step (60 min)
  localparam logic [11:0] SECS_60    = 12'h03C;
  localparam logic [11:0] SECS_600   = 12'h258;
  localparam logic [11:0] SECS_MAX   = 12'hE10;
  localparam logic [11:0] STEP_10S   = 12'h00A;
  localparam logic [11:0] STEP_1MIN  = 12'h03C;
  localparam logic [11:0] SECS_VALVE = 12'h004;
  localparam logic [11:0] SECS_SETTLE = 12'h003;

  // ----------------------------------------------------------------------
  // Schedule choice and sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCHED_NEVER  = 3'h0,
    SCHED_BEFORE = 3'h1,
    SCHED_AFTER  = 3'h2,
    SCHED_BOTH   = 3'h3,
    SCHED_SPLIT  = 3'h4
  } vpr_sched_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_LP_VENT   = 4'h1,
    ST_LP_SETTLE = 4'h3,
    ST_LP_MON    = 4'h2,
    ST_HP_FILL   = 4'h6,
    ST_HP_SETTLE = 4'h7,
    ST_HP_MON    = 4'h5,
    ST_LOCKOUT   = 4'h4
  } vpr_state_t;

  // Burner sequence events in, one-cycle pulses
  typedef struct packed {
    logic prepurge_start;
    logic run_end;
    logic lockout_reset;
  } vpr_seq_in_t;

  // Valve drives out
  typedef struct packed {
    logic upstream_valve;
    logic downstream_valve;
  } vpr_valves_t;

endpackage

// file: hdl/vps_timer.sv
// Purpose: Whole-second phase timer with a one-cycle expiry pulse
// Assumes: CYC_PER_SEC of at least 2
// Notes:   A load restarts it; expiry comes secs*CYC_PER_SEC-1 cycles later

`timescale 1ns/1ps

module vpr_timer
#(
  parameter int unsigned CYC_PER_SEC = vpr_pkg::CLK_HZ
)
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // Load and expiry
  input  wire logic                       load_i,
  input  wire logic [vpr_pkg::SECS_W-1:0] secs_i,
  output logic                            expire_o
);
  import vpr_pkg::*;

  logic [31:0]       pre_reg;
  logic [SECS_W-1:0] sec_reg;
  logic              tick;

  // One-second prescaler; starting at one aligns expiry to valve timing
  assign tick = (pre_reg == 32'(CYC_PER_SEC - 1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pre_reg <= 32'h0000_0000;
    else if (load_i || tick)
      pre_reg <= load_i ? 32'h0000_0001 : 32'h0000_0000;
    else
      pre_reg <= pre_reg + 32'h0000_0001;
  end

  // Seconds left; zero seconds expires at once
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sec_reg  <= 12'h000;
      expire_o <= 1'b0;
    end
    else if (load_i)
    begin
      sec_reg  <= secs_i;
      expire_o <= (secs_i == 12'h000);
    end
    else
    begin
      expire_o <= tick && (sec_reg == 12'h001);
      if (tick && sec_reg != 12'h000)
        sec_reg <= sec_reg - 12'h001;
    end
  end

endmodule

// file: hdl/vps_sched.sv
// Purpose: Schedules and runs the valve seat leak test in a burner cycle
// Assumes: Burner sequencer pulses its events on this clock
// Notes:   Settings are taken only while idle; a test never changes midway

`timescale 1ns/1ps

// Summary of operation
// - Five schedule choices: never, before, after, both, split
// - Defaults to never; never runs no test
// - Before: full test with pre-purge
// - After: full test when run ends
// - Both: full test at both points
// - Split: high test before, low after
// - Programmable test time sets monitor length
// - Low test: open downstream four seconds
// - Settle three seconds, lock if switch on
// - High test: fill, settle, lock if off
// - Time steps 1 s, 10 s, 1 min
module vpr_sched
#(
  parameter int unsigned CYC_PER_SEC = vpr_pkg::CLK_HZ
)
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  // Commissioning settings
  input  wire vpr_pkg::vpr_sched_t        sched_i,
  input  wire logic [vpr_pkg::CODE_W-1:0] time_code_i,
  // Burner sequence events
  input  wire vpr_pkg::vpr_seq_in_t       seq_i,
  // Valve train
  input  wire logic                       proving_pressure_switch_i,
  output vpr_pkg::vpr_valves_t            valves_o,
  // Status to burner sequencer
  output logic                            before_done_o,
  output logic                            after_done_o,
  output logic                            busy_o,
  output logic                            lockout_o
);
  import vpr_pkg::*;
  // ----------------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  logic pps_meta_reg;
  logic pps_reg;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end
  // Switch is a field pin, so two stages before any use
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pps_meta_reg <= 1'b0;
      pps_reg      <= 1'b0;
    end
    else
    begin
      pps_meta_reg <= proving_pressure_switch_i;
      pps_reg      <= pps_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  vpr_state_t        state_reg;
  vpr_state_t        state_next;
  vpr_sched_t        sched_reg;
  logic [SECS_W-1:0] test_secs_reg;
  // Step code to seconds; codes past the top clamp to 60 minutes
  function automatic logic [SECS_W-1:0] code_to_secs(
    input logic [CODE_W-1:0] code);
    logic [SECS_W-1:0] c;
    c = {4'h0, code};
    if (code <= CODE_1S)
      code_to_secs = c;
    else if (code <= CODE_10S)
      code_to_secs = SECS_60 + 12'((c - {4'h0, CODE_1S}) * STEP_10S);
    else if (code <= CODE_MAX)
      code_to_secs = SECS_600 + 12'((c - {4'h0, CODE_10S}) * STEP_1MIN);
    else
      code_to_secs = SECS_MAX;
  endfunction
  // Captured only while idle; a running test keeps its settings
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sched_reg     <= SCHED_NEVER;
      test_secs_reg <= 12'h000;
    end
    else if (state_reg == ST_IDLE)
    begin
      sched_reg     <= sched_i;
      test_secs_reg <= code_to_secs(time_code_i);
    end
  end

  // ----------------------------------------------------------------------
  // Test sequencer
  // ----------------------------------------------------------------------
  logic              do_hp_reg;  // High test follows the low test
  logic              after_reg;  // Test belongs to the after point
  logic              tmr_exp;
  logic              tmr_load;
  logic [SECS_W-1:0] tmr_secs;
  logic              start_before;
  logic              start_after;
  assign start_before = (state_reg == ST_IDLE) && seq_i.prepurge_start;
  assign start_after  = (state_reg == ST_IDLE) && seq_i.run_end;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (start_before)
        begin
          if (sched_reg == SCHED_BEFORE || sched_reg == SCHED_BOTH)
            state_next = ST_LP_VENT;
          else if (sched_reg == SCHED_SPLIT)
            state_next = ST_HP_FILL;
        end
        else if (start_after)
        begin
          if (sched_reg == SCHED_AFTER || sched_reg == SCHED_BOTH ||
              sched_reg == SCHED_SPLIT)
            state_next = ST_LP_VENT;
        end
      ST_LP_VENT:   if (tmr_exp) state_next = ST_LP_SETTLE;
      ST_LP_SETTLE: if (tmr_exp) state_next = ST_LP_MON;
      ST_LP_MON:
        if (pps_reg)
          state_next = ST_LOCKOUT;
        else if (tmr_exp)
          state_next = do_hp_reg ? ST_HP_FILL : ST_IDLE;
      ST_HP_FILL:   if (tmr_exp) state_next = ST_HP_SETTLE;
      ST_HP_SETTLE: if (tmr_exp) state_next = ST_HP_MON;
      ST_HP_MON:
        if (!pps_reg)
          state_next = ST_LOCKOUT;
        else if (tmr_exp)
          state_next = ST_IDLE;
      ST_LOCKOUT:   if (seq_i.lockout_reset) state_next = ST_IDLE;
      default:      state_next = ST_LOCKOUT; // Illegal code fails safe
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end
  // Which point and whether the high test follows, fixed at start
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      do_hp_reg <= 1'b0;
      after_reg <= 1'b0;
    end
    else if (state_reg == ST_IDLE)
    begin
      do_hp_reg <= !(start_after && sched_reg == SCHED_SPLIT);
      after_reg <= start_after && !start_before;
    end
  end

  // ----------------------------------------------------------------------
  // Phase timer, loaded on every entry to a timed phase
  // ----------------------------------------------------------------------
  assign tmr_load = (state_next != state_reg) && (state_next != ST_IDLE) &&
                    (state_next != ST_LOCKOUT);
  always_comb
  begin
    tmr_secs = test_secs_reg;
    if (state_next == ST_LP_VENT || state_next == ST_HP_FILL)
      tmr_secs = SECS_VALVE;
    else if (state_next == ST_LP_SETTLE || state_next == ST_HP_SETTLE)
      tmr_secs = SECS_SETTLE;
  end
  vpr_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_vpr_timer (
    .clk_i(clk_i), .rst_n_i(rst_n), .load_i(tmr_load),
    .secs_i(tmr_secs), .expire_o(tmr_exp));

  // ----------------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------------
  logic finish;
  assign finish = (state_reg != ST_IDLE) && (state_next == ST_IDLE) &&
                  (state_reg != ST_LOCKOUT);
  // Valves follow the next state so lockout drops them in one edge
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      valves_o <= '0;
    else
    begin
      valves_o.downstream_valve <= (state_next == ST_LP_VENT);
      valves_o.upstream_valve   <= (state_next == ST_HP_FILL);
    end
  end
  // Done pulses; a skipped point answers at once, except a run end in the same cycle as a pre-purge start
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      before_done_o <= 1'b0;
      after_done_o  <= 1'b0;
      busy_o        <= 1'b0;
      lockout_o     <= 1'b0;
    end
    else
    begin
      before_done_o <= (start_before && state_next == ST_IDLE) ||
                       (finish && !after_reg);
      after_done_o  <= (start_after && !start_before &&
                        state_next == ST_IDLE) || (finish && after_reg);
      busy_o        <= (state_next != ST_IDLE) &&
                       (state_next != ST_LOCKOUT);
      lockout_o     <= (state_next == ST_LOCKOUT);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  // Cycles of open downstream valve, for the vent length check
  logic [31:0] dn_on_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      dn_on_cnt_reg <= 32'h0000_0000;
    else
      dn_on_cnt_reg <= valves_o.downstream_valve ?
                       dn_on_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  sequence idle_start_s(logic ev, vpr_sched_t s);
    state_reg == ST_IDLE && ev && sched_reg == s;
  endsequence
  never_no_test_a: assert property (
    idle_start_s(seq_i.prepurge_start | seq_i.run_end, SCHED_NEVER) |=>
      state_reg == ST_IDLE && valves_o == '0)
    else $error("never schedule started a test");
  before_start_a: assert property (
    idle_start_s(seq_i.prepurge_start, SCHED_BEFORE) |=>
      state_reg == ST_LP_VENT && valves_o.downstream_valve)
    else $error("before schedule did not vent");
  after_start_a: assert property (
    idle_start_s(seq_i.run_end, SCHED_AFTER) |=>
      state_reg == ST_LP_VENT && do_hp_reg && after_reg)
    else $error("after schedule did not start full test");
  both_start_a: assert property (
    idle_start_s(seq_i.prepurge_start, SCHED_BOTH) |=>
      state_reg == ST_LP_VENT && do_hp_reg)
    else $error("both schedule did not start full test");
  split_before_a: assert property (
    idle_start_s(seq_i.prepurge_start, SCHED_SPLIT) |=>
      state_reg == ST_HP_FILL && valves_o.upstream_valve &&
      !valves_o.downstream_valve)
    else $error("split before did not run high test only");
  vent_time_a: assert property (
    $fell(valves_o.downstream_valve) |->
      dn_on_cnt_reg == 32'(VALVE_S * CYC_PER_SEC) && !lockout_o)
    else $error("vent time wrong");
  settle_ignore_a: assert property (
    state_reg == ST_LP_SETTLE && !tmr_exp |=> !lockout_o)
    else $error("switch not ignored while settling");
  low_lock_a: assert property (
    state_reg == ST_LP_MON && pps_reg |=>
      lockout_o && valves_o == '0 ##1 state_reg == ST_LOCKOUT)
    else $error("low test leak missed");
  high_lock_a: assert property (
    state_reg == ST_HP_MON && !pps_reg |=> lockout_o && !busy_o)
    else $error("high test leak missed");
  lock_hold_a: assert property (
    lockout_o && !seq_i.lockout_reset |=>
      lockout_o && valves_o == '0 && !before_done_o && !after_done_o)
    else $error("lockout not held");
endmodule

// file: verification/vps_valve_model.sv
// Purpose: Valve train seen by the scheduler: two valves, one switch
// Assumes: Switch high while the space between the seats holds pressure
// Notes:   Leak inputs make a seat pass gas while both valves are closed

`timescale 1ns/1ps

module vpr_valve_model
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // Valve drives and commanded faults
  input  wire vpr_pkg::vpr_valves_t valves_i,
  input  wire logic                 up_leak_i,
  input  wire logic                 dn_leak_i,
  // Proving pressure switch
  output logic                      switch_o
);
  import vpr_pkg::*;

  // ----------------------------------------------------------------------
  // Pressure in the space between the seats
  // ----------------------------------------------------------------------
  // An open valve wins over a leak, as gas flow dwarfs seat leakage
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      switch_o <= 1'b0;
    else if (valves_i.downstream_valve)
      switch_o <= 1'b0;
    else if (valves_i.upstream_valve)
      switch_o <= 1'b1;
    else if (up_leak_i)
      switch_o <= 1'b1;
    else if (dn_leak_i)
      switch_o <= 1'b0;
  end
endmodule

// file: verification/test_vps_sched.sv
// Purpose: Self-checking bench for the valve leak test scheduler
// Assumes: One second shortened to CPS clock cycles
// Notes:   Inputs change on the falling edge; outputs sampled there too

`timescale 1ns/1ps

module test_vpr_sched;
  import vpr_pkg::*;

  localparam int unsigned CPS = 10;

  logic        clk_i         = 1'b0;
  logic        resetn_i      = 1'b0;
  vpr_sched_t  sched_i       = SCHED_NEVER;
  logic [7:0]  time_code_i   = 8'h01;
  vpr_seq_in_t seq_i         = '0;
  logic        up_leak       = 1'b0;
  logic        dn_leak       = 1'b0;
  logic        sw;
  vpr_valves_t valves_o;
  logic        before_done_o;
  logic        after_done_o;
  logic        busy_o;
  logic        lockout_o;
  int          miscompares   = 0;
  int          compares      = 0;
  int          cycles        = 0;
  logic [15:0] n_up;
  logic [15:0] n_dn;
  logic [15:0] n_busy;
  logic        got_done;
  logic        got_lock;

  vpr_sched #(.CYC_PER_SEC(CPS)) u_vpr_sched (
    .clk_i(clk_i), .resetn_i(resetn_i), .sched_i(sched_i),
    .time_code_i(time_code_i), .seq_i(seq_i),
    .proving_pressure_switch_i(sw), .valves_o(valves_o),
    .before_done_o(before_done_o), .after_done_o(after_done_o),
    .busy_o(busy_o), .lockout_o(lockout_o));

  vpr_valve_model u_vpr_valve_model (
    .clk_i(clk_i), .resetn_i(resetn_i), .valves_i(valves_o),
    .up_leak_i(up_leak), .dn_leak_i(dn_leak), .switch_o(sw));

  // Free-running clock, 40 ns period
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  // Hang guard, well above the total of all tests
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk_val(input string what, input logic [15:0] got,
                         input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, what, got,
               exp);
    end
  endtask

  // Phase edges may each shift by a cycle, so allow a small margin
  task automatic chk_near(input string what, input logic [15:0] got,
                          input logic [15:0] exp);
    compares++;
    if ((got + 16'd8 >= exp && got <= exp + 16'd8) !== 1'b1)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %0d near %0d", $time, what,
               got, exp);
    end
  endtask

  // One-cycle event pulse: 0 pre-purge, 1 run end, 2 lockout reset
  task automatic pulse(input int w);
    @(negedge clk_i);
    seq_i.prepurge_start = (w == 0);
    seq_i.run_end        = (w == 1);
    seq_i.lockout_reset  = (w == 2);
    @(negedge clk_i);
    seq_i = '0;
  endtask

  // Fire a sequence point and tally valve and busy cycles until it ends
  task automatic run_point(input int w);
    n_up = '0;
    n_dn = '0;
    n_busy = '0;
    got_done = 1'b0;
    got_lock = 1'b0;
    pulse(w);
    for (int i = 0; i < 20000 && !got_done && !got_lock; i++)
    begin
      if (valves_o.upstream_valve === 1'b1) n_up++;
      if (valves_o.downstream_valve === 1'b1) n_dn++;
      if (busy_o === 1'b1) n_busy++;
      got_done = (w == 0) ? (before_done_o === 1'b1)
                          : (after_done_o === 1'b1);
      got_lock = (lockout_o === 1'b1);
      if (!got_done && !got_lock) @(negedge clk_i);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Every schedule at both points, one second of monitoring per test
  task automatic t_schedules();
    logic full;
    logic hi;
    logic lo;
    for (int k = 0; k < 5; k++)
      for (int p = 0; p < 2; p++)
      begin
        sched_i = vpr_sched_t'(k);
        time_code_i = 8'h01;
        full = (k == 1 && p == 0) || (k == 2 && p == 1) || k == 3;
        hi = full || (k == 4 && p == 0);
        lo = full || (k == 4 && p == 1);
        run_point(p);
        chk_val("done", 16'(got_done), 16'h0001);
        chk_val("up on", n_up, hi ? 16'd40 : 16'd0);
        chk_val("down on", n_dn, lo ? 16'd40 : 16'd0);
        chk_near("busy", n_busy, 16'((lo + hi) * 8 * CPS));
      end
    $display("test schedules done");
  endtask

  // Seat leak: low test catches the upstream seat, high the downstream
  task automatic t_lock(input logic up);
    sched_i = SCHED_BEFORE;
    time_code_i = 8'h02;
    up_leak = up;
    dn_leak = !up;
    run_point(0);
    chk_val("lockout", 16'(got_lock), 16'h0001);
    chk_near("lock time", n_busy, up ? 16'(7 * CPS) : 16'(16 * CPS));
    chk_val("up on", n_up, up ? 16'd0 : 16'd40);
    chk_val("down on", n_dn, 16'd40);
    repeat (3) @(negedge clk_i);
    chk_val("valves", 16'(valves_o), 16'h0000);
    pulse(0);
    repeat (3) @(negedge clk_i);
    chk_val("busy held", 16'(busy_o), 16'h0000);
    chk_val("lock held", 16'(lockout_o), 16'h0001);
    up_leak = 1'b0;
    dn_leak = 1'b0;
    pulse(2);
    @(negedge clk_i);
    chk_val("lock clear", 16'(lockout_o), 16'h0000);
    $display("test lockout done");
  endtask

  // Step ladder edges, measured on a lone high test
  task automatic t_time_code();
    logic [7:0]  codes [5];
    logic [15:0] secs [5];
    codes = '{8'h00, 8'h3C, 8'h3D, 8'h72, 8'h73};
    secs = '{16'd0, 16'd60, 16'd70, 16'd600, 16'd660};
    sched_i = SCHED_SPLIT;
    for (int k = 0; k < 5; k++)
    begin
      time_code_i = codes[k];
      run_point(0);
      chk_val("done", 16'(got_done), 16'h0001);
      chk_val("up on", n_up, 16'd40);
      chk_near("busy", n_busy, 16'((7 + secs[k]) * CPS));
    end
    $display("test time code done");
  endtask

  task automatic final_report();
    $display("counts: %0d compares, %0d miscompares", compares,
             miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_schedules();
    t_lock(1'b1);
    t_lock(1'b0);
    t_time_code();
    final_report();
  end
endmodule
